// >>> common/irq_ready_pkg.sv
// constants and types shared by the interrupt and ready output glue
`default_nettype none
package irq_ready_pkg;
	localparam int unsigned num_chan = 4;
	localparam int unsigned addr_width = 4;
	localparam int unsigned data_width = 8;
	localparam int unsigned fifo_level_width = 7;
	// register map, one byte per register
	localparam logic [3:0] mcr_a_addr = 4'h0;
	localparam logic [3:0] mcr_b_addr = 4'h1;
	localparam logic [3:0] mcr_c_addr = 4'h2;
	localparam logic [3:0] mcr_d_addr = 4'h3;
	localparam logic [3:0] cfg_addr = 4'h4;
	localparam logic [3:0] trig_addr = 4'h5;
	localparam logic [3:0] pin_status_addr = 4'h6;
	localparam logic [3:0] fifo_status_addr = 4'h7;
	localparam logic [7:0] unmapped_read = 8'h00;
	// modem control fields
	localparam int unsigned irq_output_enable_bit = 3;
	localparam logic [7:0] mcr_reset = 8'h00;
	// configuration fields: fifo enable per channel in bits 3..0
	localparam int unsigned cfg_fifo_en_lsb = 0;
	localparam logic [7:0] cfg_reset = 8'h00;
	// receive trigger level and transmit space threshold
	localparam int unsigned trig_rx_lsb = 0;
	localparam int unsigned trig_tx_lsb = 4;
	localparam logic [7:0] trig_reset = 8'h11;
	// fifo status byte layout
	localparam int unsigned fifo_status_byte_tx_lsb = 0;
	localparam int unsigned fifo_status_byte_rx_lsb = 4;
	typedef enum logic {
		bus_rw_line,
		bus_strobe
	} bus_mode_type;
endpackage : irq_ready_pkg
`default_nettype wire

// >>> common/chan_status_if.sv
// per-channel status travelling from the top to the ready logic
`default_nettype none
interface chan_status_if;
	import irq_ready_pkg::*;
	logic [num_chan-1:0] fifo_en;
	logic [num_chan-1:0] thr_empty;
	logic [num_chan-1:0] rhr_full;
	logic [num_chan*fifo_level_width-1:0] tx_level;
	logic [num_chan*fifo_level_width-1:0] rx_level;
	logic [3:0] rx_trig;
	logic [3:0] tx_trig;
	logic [num_chan-1:0] tx_ready_n;
	logic [num_chan-1:0] rx_ready_n;
	modport top (output fifo_en, thr_empty, rhr_full, tx_level, rx_level, rx_trig, tx_trig,
		input tx_ready_n, rx_ready_n);
	modport ready (input fifo_en, thr_empty, rhr_full, tx_level, rx_level, rx_trig, tx_trig,
		output tx_ready_n, rx_ready_n);
endinterface : chan_status_if
`default_nettype wire

// >>> verilog/chan_ready_logic.sv
// per-channel transmit and receive ready decode
`default_nettype none
module chan_ready_logic (
	chan_status_if.ready st
);
	import irq_ready_pkg::*;
	// thresholds scale the 4-bit fields by 4 across the 64-entry fifo
	genvar g;
	generate
		for (g = 0; g < num_chan; g++) begin : g_chan
			logic [fifo_level_width-1:0] txl;
			logic [fifo_level_width-1:0] rxl;
			logic [fifo_level_width-1:0] tx_th;
			logic [fifo_level_width-1:0] rx_th;
			always_comb begin
				txl = st.tx_level[g*fifo_level_width +: fifo_level_width];
				rxl = st.rx_level[g*fifo_level_width +: fifo_level_width];
				tx_th = {1'b0, st.tx_trig, 2'b00};
				rx_th = {1'b0, st.rx_trig, 2'b00};
				// fifo off: holding register state decides
				if (st.fifo_en[g]) begin
					st.tx_ready_n[g] = !(txl <= tx_th);
					st.rx_ready_n[g] = !((rxl >= rx_th) && (rxl != '0));
				end else begin
					st.tx_ready_n[g] = !st.thr_empty[g];
					st.rx_ready_n[g] = !st.rhr_full[g];
				end
			end
		end
	endgenerate
endmodule : chan_ready_logic
`default_nettype wire

// >>> verilog/irq_ready_outputs.sv
// interrupt pin drivers, ready pins and fifo status byte for a quad uart
// Overview of operation
// - strobe mode: first irq pin serves channel A, driven when its enable bit set.
// - strobe mode: pins two to four serve channels B, C, D likewise.
// - line mode: first irq pin is one active-low open-drain device request.
// - line mode: channel B, C, D irq pins held at logic zero.
// - continuous select input is active high, low when unconnected.
// - strobe mode, select high: all irq pins driven regardless of enable bits.
// - strobe mode, select low: each enable bit decides drive or float.
// - variants without the select pin tie it high or low internally.
// - each channel gives active-low tx ready from fifo or holding register.
// - each channel gives active-low rx ready from fifo or holding register.
// - combined tx ready is the AND of four channel tx ready signals.
// - combined rx ready is the AND of four channel rx ready signals.
// - status select low puts inverted tx and plain rx ready on data bus.
//
// The register offsets and strobed register access are this design's own decisions.
`default_nettype none
module irq_ready_outputs #(
	// 0: pin present; 1: tied high; 2: tied low
	parameter int unsigned sel_tie = 0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [irq_ready_pkg::addr_width-1:0] reg_addr,
	input wire logic [irq_ready_pkg::data_width-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [irq_ready_pkg::data_width-1:0] reg_rdata,
	input wire logic bus_mode_sel,
	input wire logic irq_continuous_sel,
	input wire logic [irq_ready_pkg::num_chan-1:0] chan_irq_pending,
	input wire logic [irq_ready_pkg::num_chan-1:0] thr_empty,
	input wire logic [irq_ready_pkg::num_chan-1:0] rhr_full,
	input wire logic [irq_ready_pkg::num_chan*irq_ready_pkg::fifo_level_width-1:0] tx_level,
	input wire logic [irq_ready_pkg::num_chan*irq_ready_pkg::fifo_level_width-1:0] rx_level,
	input wire logic fifo_status_sel_n,
	output logic chan_a_irq_out,
	output logic chan_a_irq_oe_n,
	output logic chan_b_irq_out,
	output logic chan_b_irq_oe_n,
	output logic chan_c_irq_out,
	output logic chan_c_irq_oe_n,
	output logic chan_d_irq_out,
	output logic chan_d_irq_oe_n,
	output logic chan_a_tx_ready_n,
	output logic chan_b_tx_ready_n,
	output logic chan_c_tx_ready_n,
	output logic chan_d_tx_ready_n,
	output logic chan_a_rx_ready_n,
	output logic chan_b_rx_ready_n,
	output logic chan_c_rx_ready_n,
	output logic chan_d_rx_ready_n,
	output logic all_tx_ready_n,
	output logic all_rx_ready_n,
	output logic [irq_ready_pkg::data_width-1:0] fifo_status_byte,
	output logic fifo_status_oe_n
);
	import irq_ready_pkg::*;

	chan_status_if st ();

	logic [data_width-1:0] mcr_q [num_chan];
	logic [data_width-1:0] mcr_d [num_chan];
	logic [data_width-1:0] cfg_q;
	logic [data_width-1:0] cfg_d;
	logic [data_width-1:0] trig_q;
	logic [data_width-1:0] trig_d;
	logic [data_width-1:0] rdata_q;
	logic [data_width-1:0] rdata_d;
	logic [num_chan-1:0] irq_val_q;
	logic [num_chan-1:0] irq_val_d;
	logic [num_chan-1:0] irq_oe_n_q;
	logic [num_chan-1:0] irq_oe_n_d;
	logic [num_chan-1:0] txr_n_q;
	logic [num_chan-1:0] rxr_n_q;
	logic all_txr_n_q;
	logic all_rxr_n_q;
	logic [data_width-1:0] fifo_status_byte_q;
	logic [data_width-1:0] fifo_status_byte_d;
	logic fifo_status_byte_oe_n_q;
	logic sel_eff;
	logic [num_chan-1:0] mcr_oe;
	bus_mode_type mode;

	// feed channel status into the ready decoder
	assign st.fifo_en = cfg_q[cfg_fifo_en_lsb +: num_chan];
	assign st.thr_empty = thr_empty;
	assign st.rhr_full = rhr_full;
	assign st.tx_level = tx_level;
	assign st.rx_level = rx_level;
	assign st.rx_trig = trig_q[trig_rx_lsb +: 4];
	assign st.tx_trig = trig_q[trig_tx_lsb +: 4];

	chan_ready_logic u_ready (
		.st(st)
	);

	// bus mode from the select pin; host owns its level
	assign mode = bus_mode_sel ? bus_strobe : bus_rw_line;
	// package tie overrides the pin, which idles low through its pull-down
	assign sel_eff = (sel_tie == 1) ? 1'b1 :
		(sel_tie == 2) ? 1'b0 : irq_continuous_sel;

	// register writes and reads; read data stand one cycle after the strobe
	always_comb begin
		for (int i = 0; i < num_chan; i++) begin
			mcr_d[i] = mcr_q[i];
		end
		cfg_d = cfg_q;
		trig_d = trig_q;
		rdata_d = unmapped_read;
		if (reg_wr) begin
			case (reg_addr)
				mcr_a_addr: mcr_d[0] = reg_wdata;
				mcr_b_addr: mcr_d[1] = reg_wdata;
				mcr_c_addr: mcr_d[2] = reg_wdata;
				mcr_d_addr: mcr_d[3] = reg_wdata;
				cfg_addr: cfg_d = reg_wdata;
				trig_addr: trig_d = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				mcr_a_addr: rdata_d = mcr_q[0];
				mcr_b_addr: rdata_d = mcr_q[1];
				mcr_c_addr: rdata_d = mcr_q[2];
				mcr_d_addr: rdata_d = mcr_q[3];
				cfg_addr: rdata_d = cfg_q;
				trig_addr: rdata_d = trig_q;
				pin_status_addr: rdata_d = {irq_oe_n_q, irq_val_q};
				fifo_status_addr: rdata_d = fifo_status_byte_d;
				default: rdata_d = unmapped_read;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < num_chan; i++) begin
				mcr_q[i] <= mcr_reset;
			end
			cfg_q <= cfg_reset;
			trig_q <= trig_reset;
			rdata_q <= unmapped_read;
		end else begin
			for (int i = 0; i < num_chan; i++) begin
				mcr_q[i] <= mcr_d[i];
			end
			cfg_q <= cfg_d;
			trig_q <= trig_d;
			rdata_q <= rdata_d;
		end
	end

	// interrupt pin drive; enables reset to float since the bit defaults to 0
	always_comb begin
		for (int i = 0; i < num_chan; i++) begin
			mcr_oe[i] = mcr_q[i][irq_output_enable_bit];
		end
		irq_val_d = '0;
		irq_oe_n_d = '1;
		case (mode)
			bus_strobe: begin
				for (int i = 0; i < num_chan; i++) begin
					irq_val_d[i] = chan_irq_pending[i];
					// select high forces drive, otherwise the enable bit rules
					irq_oe_n_d[i] = !(sel_eff || mcr_oe[i]);
				end
			end
			bus_rw_line: begin
				// open drain: pull low only while any channel requests
				irq_val_d[0] = 1'b0;
				irq_oe_n_d[0] = !(|chan_irq_pending);
				// unused pins actively held at zero
				irq_oe_n_d[num_chan-1:1] = '0;
			end
			default: begin
				irq_val_d = '0;
				irq_oe_n_d = '1;
			end
		endcase
	end

	// status byte: tx bits inverted, rx bits as on the pins
	always_comb begin
		fifo_status_byte_d = '0;
		fifo_status_byte_d[fifo_status_byte_tx_lsb +: num_chan] = ~st.tx_ready_n;
		fifo_status_byte_d[fifo_status_byte_rx_lsb +: num_chan] = st.rx_ready_n;
	end

	// all pins registered so outputs come straight from flip-flops
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			irq_val_q <= '0;
			irq_oe_n_q <= '1;
			txr_n_q <= '1;
			rxr_n_q <= '1;
			all_txr_n_q <= 1'b1;
			all_rxr_n_q <= 1'b1;
			fifo_status_byte_q <= '0;
			fifo_status_byte_oe_n_q <= 1'b1;
		end else begin
			irq_val_q <= irq_val_d;
			irq_oe_n_q <= irq_oe_n_d;
			txr_n_q <= st.tx_ready_n;
			rxr_n_q <= st.rx_ready_n;
			all_txr_n_q <= &st.tx_ready_n;
			all_rxr_n_q <= &st.rx_ready_n;
			fifo_status_byte_q <= fifo_status_byte_d;
			// no address decode needed for the status byte
			fifo_status_byte_oe_n_q <= fifo_status_sel_n;
		end
	end

	assign reg_rdata = rdata_q;
	assign chan_a_irq_out = irq_val_q[0];
	assign chan_b_irq_out = irq_val_q[1];
	assign chan_c_irq_out = irq_val_q[2];
	assign chan_d_irq_out = irq_val_q[3];
	assign chan_a_irq_oe_n = irq_oe_n_q[0];
	assign chan_b_irq_oe_n = irq_oe_n_q[1];
	assign chan_c_irq_oe_n = irq_oe_n_q[2];
	assign chan_d_irq_oe_n = irq_oe_n_q[3];
	assign chan_a_tx_ready_n = txr_n_q[0];
	assign chan_b_tx_ready_n = txr_n_q[1];
	assign chan_c_tx_ready_n = txr_n_q[2];
	assign chan_d_tx_ready_n = txr_n_q[3];
	assign chan_a_rx_ready_n = rxr_n_q[0];
	assign chan_b_rx_ready_n = rxr_n_q[1];
	assign chan_c_rx_ready_n = rxr_n_q[2];
	assign chan_d_rx_ready_n = rxr_n_q[3];
	assign all_tx_ready_n = all_txr_n_q;
	assign all_rx_ready_n = all_rxr_n_q;
	assign fifo_status_byte = fifo_status_byte_q;
	assign fifo_status_oe_n = fifo_status_byte_oe_n_q;
endmodule : irq_ready_outputs
`default_nettype wire

// >>> sim/host_model.sv
// host side model: bus mode straps and the pulled-up shared interrupt line
`default_nettype none
module host_model (
	input wire logic want_strobe,
	input wire logic want_sel,
	input wire logic chan_a_irq_out,
	input wire logic chan_a_irq_oe_n,
	output logic bus_mode_sel,
	output logic irq_continuous_sel,
	output logic line_irq_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// strap high picks the strobe bus, low the line bus
	assign bus_mode_sel = want_strobe;
	// never raised on the line bus, where it would fight the shared request
	assign irq_continuous_sel = want_strobe & want_sel;
	// board pull-up wins while the open-drain pin is released
	assign line_irq_n = chan_a_irq_oe_n ? 1'b1 : chan_a_irq_out;
endmodule : host_model
`default_nettype wire

// >>> sim/irq_ready_checker.sv
// concurrent checks on the interrupt and ready pins
`default_nettype none
module irq_ready_checker import irq_ready_pkg::*; (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic bus_mode_sel,
	input wire logic irq_continuous_sel,
	input wire logic [3:0] chan_irq_pending,
	input wire logic chan_a_irq_out,
	input wire logic chan_b_irq_out,
	input wire logic chan_c_irq_out,
	input wire logic chan_d_irq_out,
	input wire logic chan_a_irq_oe_n,
	input wire logic chan_b_irq_oe_n,
	input wire logic chan_c_irq_oe_n,
	input wire logic chan_d_irq_oe_n,
	input wire logic chan_a_tx_ready_n,
	input wire logic chan_b_tx_ready_n,
	input wire logic chan_c_tx_ready_n,
	input wire logic chan_d_tx_ready_n,
	input wire logic chan_a_rx_ready_n,
	input wire logic chan_b_rx_ready_n,
	input wire logic chan_c_rx_ready_n,
	input wire logic chan_d_rx_ready_n,
	input wire logic all_tx_ready_n,
	input wire logic all_rx_ready_n,
	input wire logic [7:0] fifo_status_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// pins gathered channel A in bit 0
	wire [3:0] io = {chan_d_irq_out, chan_c_irq_out, chan_b_irq_out, chan_a_irq_out};
	wire [3:0] oe = {chan_d_irq_oe_n, chan_c_irq_oe_n, chan_b_irq_oe_n, chan_a_irq_oe_n};
	wire [3:0] tx = {chan_d_tx_ready_n, chan_c_tx_ready_n, chan_b_tx_ready_n, chan_a_tx_ready_n};
	wire [3:0] rx = {chan_d_rx_ready_n, chan_c_rx_ready_n, chan_b_rx_ready_n, chan_a_rx_ready_n};
	a_irq_follow: assert property (bus_mode_sel |=> io == $past(chan_irq_pending))
		else $error("irq pins do not follow pending");
	a_sel_drive: assert property (bus_mode_sel && irq_continuous_sel |=> oe == 4'h0)
		else $error("irq pins not driven under continuous select");
	a_line_b_low: assert property (!bus_mode_sel |=> io == 4'h0 && oe[3:1] == 3'h0)
		else $error("unused irq pins not held low");
	a_line_req: assert property (!bus_mode_sel |=> oe[0] == ($past(chan_irq_pending) == 4'h0))
		else $error("shared request wrong");
	a_tx_and: assert property (all_tx_ready_n == &tx)
		else $error("combined tx ready wrong");
	a_rx_and: assert property (all_rx_ready_n == &rx)
		else $error("combined rx ready wrong");
	// first edge after release still samples reset values, hence the past guard
	a_fifo_status_byte_byte: assert property ($past(rst_b) |-> fifo_status_byte == {rx, ~tx})
		else $error("status byte wrong");
	a_en_decide: assert property (reg_wr && reg_addr == mcr_a_addr ##1
		bus_mode_sel && !irq_continuous_sel |=> chan_a_irq_oe_n == !$past(reg_wdata[3], 2))
		else $error("enable bit does not decide drive");
	c_line_req: cover property (!bus_mode_sel && chan_irq_pending != 4'h0);
	c_sel_on: cover property (bus_mode_sel && irq_continuous_sel);
	c_tx_ready: cover property (!all_tx_ready_n ##1 all_tx_ready_n);
endmodule : irq_ready_checker
bind irq_ready_outputs irq_ready_checker chk_i (.*);
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the interrupt and ready output glue
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_ready_pkg::*;
	logic mclk, rst_b, reg_wr, reg_rd, fifo_status_sel_n, want_strobe, want_sel, line_irq_n;
	logic bus_mode_sel, irq_continuous_sel, all_tx_ready_n, all_rx_ready_n, fifo_status_oe_n;
	logic [3:0] reg_addr, chan_irq_pending, thr_empty, rhr_full, mcr_en, fifo_en;
	logic [7:0] reg_wdata, reg_rdata, fifo_status_byte, trig, ei;
	logic [9:0] er;
	logic [27:0] tx_level, rx_level;
	logic chan_a_irq_out, chan_b_irq_out, chan_c_irq_out, chan_d_irq_out;
	logic chan_a_irq_oe_n, chan_b_irq_oe_n, chan_c_irq_oe_n, chan_d_irq_oe_n;
	logic chan_a_tx_ready_n, chan_b_tx_ready_n, chan_c_tx_ready_n, chan_d_tx_ready_n;
	logic chan_a_rx_ready_n, chan_b_rx_ready_n, chan_c_rx_ready_n, chan_d_rx_ready_n;
	int bad_count, cmp_count, tl, rl;
	wire [7:0] irq_pins = {chan_d_irq_oe_n, chan_c_irq_oe_n, chan_b_irq_oe_n, chan_a_irq_oe_n,
		chan_d_irq_out, chan_c_irq_out, chan_b_irq_out, chan_a_irq_out};
	wire [9:0] rdy_pins = {all_rx_ready_n, all_tx_ready_n, chan_d_rx_ready_n, chan_c_rx_ready_n,
		chan_b_rx_ready_n, chan_a_rx_ready_n, chan_d_tx_ready_n, chan_c_tx_ready_n,
		chan_b_tx_ready_n, chan_a_tx_ready_n};
	irq_ready_outputs uut (.*);
	host_model host (.want_strobe(want_strobe), .want_sel(want_sel),
		.chan_a_irq_out(chan_a_irq_out), .chan_a_irq_oe_n(chan_a_irq_oe_n),
		.bus_mode_sel(bus_mode_sel), .irq_continuous_sel(irq_continuous_sel),
		.line_irq_n(line_irq_n));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk({2'b00, reg_rdata}, {2'b00, exp});
	endtask : rd
	task automatic results();
		$display("checks %0d errors %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// run is about 35 us, so this only trips on a hang
	initial begin
		#100000;
		bad_count++;
		$display("ERROR %0t: timeout", $time);
		results();
	end
	initial begin
		{rst_b, reg_wr, reg_rd, want_strobe, want_sel, chan_irq_pending} = '0;
		{reg_addr, reg_wdata, thr_empty, rhr_full, tx_level, rx_level} = '0;
		fifo_status_sel_n = 1'b1;
		void'($urandom(32'h10BFF7A6));
		repeat (4) @(posedge mclk);
		#1 chk({irq_pins, 2'b00}, {8'hF0, 2'b00});
		chk(rdy_pins, 10'h3FF);
		chk({1'b0, fifo_status_oe_n, fifo_status_byte}, 10'h100);
		rst_b <= 1'b1;
		// reset values, then an unmapped place
		for (int a = 0; a < 6; a++)
			rd(4'(a), a == 5 ? 8'h11 : 8'h00);
		rd(4'hF, 8'h00);
		for (int n = 0; n < 250; n++) begin
			for (int c = 0; c < 4; c++) begin
				mcr_en[c] = 1'($urandom);
				wr(4'(c), {4'h0, mcr_en[c], 3'h0});
				rd(4'(c), {4'h0, mcr_en[c], 3'h0});
			end
			fifo_en = 4'($urandom);
			trig = 8'($urandom);
			wr(cfg_addr, {4'h0, fifo_en});
			wr(trig_addr, trig);
			wr(pin_status_addr, 8'hFF);
			@(posedge mclk);
			want_strobe <= 1'($urandom);
			want_sel <= 1'($urandom);
			chan_irq_pending <= 4'($urandom);
			thr_empty <= 4'($urandom);
			rhr_full <= 4'($urandom);
			fifo_status_sel_n <= 1'($urandom);
			for (int c = 0; c < 4; c++) begin
				tx_level[7*c +: 7] <= 7'($urandom_range(64));
				rx_level[7*c +: 7] <= 7'($urandom_range(64));
			end
			@(posedge mclk);
			#1;
			// reference model of the pins from the held inputs
			ei = '0;
			for (int c = 0; c < 4; c++) begin
				tl = int'(tx_level[7*c +: 7]);
				rl = int'(rx_level[7*c +: 7]);
				if (want_strobe) begin
					ei[c] = chan_irq_pending[c];
					ei[c+4] = !(want_sel || mcr_en[c]);
				end else
					ei[c+4] = (c == 0) && (chan_irq_pending == 4'h0);
				if (fifo_en[c]) begin
					er[c] = !(tl <= 4 * int'(trig[7:4]));
					er[c+4] = !(rl >= 4 * int'(trig[3:0]) && rl != 0);
				end else begin
					er[c] = !thr_empty[c];
					er[c+4] = !rhr_full[c];
				end
			end
			er[8] = &er[3:0];
			er[9] = &er[7:4];
			chk({1'b0, line_irq_n, irq_pins}, {1'b0, ei[4] | ei[0], ei});
			chk(rdy_pins, er);
			chk({1'b0, fifo_status_oe_n, fifo_status_byte},
				{1'b0, fifo_status_sel_n, er[7:4], ~er[3:0]});
			rd(pin_status_addr, ei);
			rd(fifo_status_addr, {er[7:4], ~er[3:0]});
		end
		results();
	end
endmodule : tb
`default_nettype wire
